/* File: dcsm_status_mux.sv */
// Status reporting multiplexer of the disk control logic.
// Assumes event inputs are one-cycle pulses from logic on clk; drive status is a pin group.
// Overview of operation
// - Select code on channel 09, status on 04
// - Upper hex digit selects one of thirteen
// - Read in progress, pattern read to checkword
// - Write in progress, pattern write onward
// - Checkword error refreshed after read checkword
// - Composite bit ORs checkword, parity, abort, lost data, sector length errors and compare fail
// - Parity error sets bit, halts directors
// - Pattern abort sets bit, stops operation
// - Lost data sets bit, stops at once
// - Sector length error sets bit, stops
// - Execute bit, cleared by stops
// - Bit 9 double density when option fitted
// - Compare done and fail, cleared next compare
// - Correctable/uncorrectable, cleared next correction start
// - Status word two decode bits
// - Register bus, word counter, buffer words
// - Checkword generator halves on 7000, 8000
// - Director register slices on A000, F000
// - Pointers and bit counter on C000
// - Address on D000, drive status 9000
// - Selection held, values live
// - Code 0080 clears internal status flags
`default_nettype none
`include "dcsm_defines.svh"

module dcsm_status_mux #(
  parameter bit DOUBLE_DENSITY = 1'b0                // Option fitted
) (
  input  wire logic        clk,                      // Control logic clock
  input  wire logic        resetn,                   // Async reset, active low
  input  wire logic        masterClear,              // Master clear pulse
  input  wire logic [7:0]  outChannel,               // Output channel number
  input  wire logic        outStrobe,                // Output word strobe
  input  wire logic [15:0] outData,                  // Output word
  input  wire logic [7:0]  inChannel,                // Input channel number
  input  wire logic        inStrobe,                 // Input request
  output var  logic [15:0] inData,                   // Status word returned
  output logic             inReply,                  // Input answered
  input  wire logic        patternReadStart,         // First pattern_read_director begins
  input  wire logic        readCheckDone,            // Read checkword director done
  input  wire logic        readCheckFail,            // Checkword test result
  input  wire logic        patternWriteStart,        // First pattern_write_director begins
  input  wire logic        nonWriteDataDir,          // Non-write data director begins
  input  wire logic        parityErr,                // Parity error event
  input  wire logic        clearParity,              // Clear parity function code
  input  wire logic        patternMiss,              // Pattern not found
  input  wire logic        bufferUnderOver,          // Data buffer empty/full event
  input  wire logic        sectorOverrun,            // Byte count past sector size
  input  wire logic        executeFunc,              // Execute function code
  input  wire logic        stopFunc,                 // Stop execution function code
  input  wire logic        terminateDir,             // Terminate director
  input  wire logic        compareStart,             // Compare begins
  input  wire logic        compareDecided,           // Compare decision made
  input  wire logic        compareFailed,            // Condition not met with decision
  input  wire logic        correctStart,             // Error correction director begins
  input  wire logic        correctableEvt,           // Correctable error found
  input  wire logic        uncorrectableEvt,         // Uncorrectable error found
  input  wire logic        ddUnitSel,                // Double density unit selected
  input  wire logic [9:0]  decodes,                  // Status two bits 0..9 sources
  input  wire logic        writerData,               // Writer output data
  input  wire logic        chkSerialIn,              // Checkword generator serial input
  input  wire logic [15:0] regFileBus,               // Register file bus
  input  wire logic [15:0] wordCounter,              // Word counter
  input  wire logic [15:0] dataBufOut,               // Data buffer output lines
  input  wire logic [31:0] checkGen,                 // Checkword generator
  input  wire logic [15:0] driveStatusPins,          // Selected drive status lines
  input  wire logic [31:0] directorReg,              // Director register
  input  wire logic [15:0] byteCounter,              // Byte counter
  input  wire logic [3:0]  dirInPtr,                 // Director buffer input pointer
  input  wire logic [3:0]  dirOutPtr,                // Director buffer output pointer
  input  wire logic [2:0]  bitCounter,               // Bit counter
  input  wire logic [15:0] memAddress,               // Address register
  output logic             directorHalt              // Stop loading and executing
);

  // ****************************************************************
  // Flags and selection
  // ****************************************************************
  dcsm_pkg::dcsm_sel_t  selCode;      // Held select digit
  logic [15:0]          driveM;       // Pin stage one, may be metastable
  logic [15:0]          driveA;       // Pin stage two
  logic [15:0]          driveB;       // Pin stage three
  logic [15:0]          driveStable;  // Accepted drive status
  logic                 rdProg;       // Read in progress
  logic                 wrProg;       // Write in progress
  logic                 chkErr;       // Checkword error
  logic                 parErr;       // Parity error
  logic                 pAbort;       // Pattern abort
  logic                 lost;         // Lost data
  logic                 secLen;       // Sector length error
  logic                 exec;         // Execute enabled
  logic                 cmpDone;      // Compare decided
  logic                 cmpFail;      // Compare condition not met
  logic                 corr;         // Correctable error
  logic                 uncorr;       // Uncorrectable error
  logic                 chanWrite;    // Word on channel 09
  logic                 clrStatus;    // Clear internal status code
  logic                 stopEvt;      // Any stopping error this cycle
  dcsm_pkg::dcsm_word_t statusOne;    // Assembled word one
  dcsm_pkg::dcsm_word_t statusTwo;    // Assembled word two

  // Channel number match, shared by the output and the input side
  function automatic logic chanHit(input logic [7:0] ch, input logic [7:0] code);
    return ch == code;
  endfunction

  assign chanWrite = outStrobe && chanHit(outChannel, `DCSM_OUT_CHANNEL);
  assign clrStatus = chanWrite && outData[`DCSM_CLEAR_STATUS_BIT];
  assign stopEvt   = bufferUnderOver || sectorOverrun || patternMiss;

  // Selection latched until the next channel 09 word; clear codes also reselect word one
  // Low digits are ignored here, so every special code also carries a select digit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selCode <= `DCSM_SEL_RESET;
    end else if (masterClear) begin
      selCode <= `DCSM_SEL_RESET;
    end else if (chanWrite) begin
      selCode <= outData[15:12];
    end
  end

  // ****************************************************************
  // Drive status synchroniser
  // ****************************************************************
  // Drive status comes from pins: three stages, accepted when the last two agree
  // Agreement costs a cycle but keeps a pin caught mid-change out of the word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      driveM      <= 16'h0000;
      driveA      <= 16'h0000;
      driveB      <= 16'h0000;
      driveStable <= 16'h0000;
    end else begin
      driveM <= driveStatusPins;
      driveA <= driveM;
      driveB <= driveA;
      for (int i = 0; i < 16; i++) begin
        if (driveA[i] == driveB[i]) begin
          driveStable[i] <= driveB[i];
        end
      end
    end
  end

  // ****************************************************************
  // Sequence flags
  // ****************************************************************
  // Read in progress; abnormal ends take priority over a new start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdProg <= 1'b0;
    end else if (masterClear || readCheckDone || lost || pAbort || secLen
                 || bufferUnderOver || patternMiss || sectorOverrun) begin
      rdProg <= 1'b0;
    end else if (patternReadStart) begin
      rdProg <= 1'b1;
    end
  end

  // Write in progress
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrProg <= 1'b0;
    end else if (masterClear || nonWriteDataDir || bufferUnderOver || sectorOverrun) begin
      wrProg <= 1'b0;
    end else if (patternWriteStart) begin
      wrProg <= 1'b1;
    end
  end

  // ****************************************************************
  // Error flags
  // ****************************************************************
  // Checkword error: refreshed on each read checkword, wins over a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chkErr <= 1'b0;
    end else if (readCheckDone) begin
      chkErr <= readCheckFail;
    end else if (masterClear || clrStatus) begin
      chkErr <= 1'b0;
    end
  end

  // Parity error: cleared only by its own function code or master clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parErr <= 1'b0;
    end else if (parityErr) begin
      parErr <= 1'b1;
    end else if (masterClear || clearParity) begin
      parErr <= 1'b0;
    end
  end

  // Stopping errors; each event beats a same-cycle clear
  // Each flag stands on its own, so several causes may show together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pAbort <= 1'b0;
      lost   <= 1'b0;
      secLen <= 1'b0;
    end else begin
      if (patternMiss) begin
        pAbort <= 1'b1;
      end else if (masterClear || clrStatus) begin
        pAbort <= 1'b0;
      end
      if (bufferUnderOver) begin
        lost <= 1'b1;
      end else if (masterClear || clrStatus) begin
        lost <= 1'b0;
      end
      if (sectorOverrun) begin
        secLen <= 1'b1;
      end else if (masterClear || clrStatus) begin
        secLen <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Execute and compare
  // ****************************************************************
  // Execute enable; every stop cause drops it, the stop wins over execute
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exec <= 1'b0;
    end else if (masterClear || parityErr || stopEvt || terminateDir || stopFunc) begin
      exec <= 1'b0;
    end else if (executeFunc && !parErr) begin
      exec <= 1'b1;
    end
  end

  // Compare result pair; the decision wins over a start or clear in the same cycle
  // The fail level means nothing while the done bit is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpDone <= 1'b0;
      cmpFail <= 1'b0;
    end else if (compareDecided) begin
      cmpDone <= 1'b1;
      cmpFail <= compareFailed;
    end else if (masterClear || compareStart || clrStatus) begin
      cmpDone <= 1'b0;
      cmpFail <= 1'b0;
    end
  end

  // ****************************************************************
  // Correction and halt
  // ****************************************************************
  // Correction results
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      corr   <= 1'b0;
      uncorr <= 1'b0;
    end else begin
      if (correctableEvt) begin
        corr <= 1'b1;
      end else if (masterClear || correctStart || clrStatus) begin
        corr <= 1'b0;
      end
      if (uncorrectableEvt) begin
        uncorr <= 1'b1;
      end else if (masterClear || correctStart || clrStatus) begin
        uncorr <= 1'b0;
      end
    end
  end

  // Parity error halts loading and execution; a director in flight finishes outside
  // Limitation: the director engine itself must let the active director complete
  assign directorHalt = parErr;

  // ****************************************************************
  // Status words
  // ****************************************************************
  // Word one assembled from live flags; unused positions zero
  // Bit 9 stays zero unless the double density option is fitted
  always_comb begin
    statusOne = 16'h0000;
    statusOne[`DCSM_B_READ]    = rdProg;
    statusOne[`DCSM_B_WRITE]   = wrProg;
    statusOne[`DCSM_B_CHKERR]  = chkErr;
    statusOne[`DCSM_B_COMPOS]  = chkErr | parErr | pAbort | lost | secLen
                                 | (cmpDone & cmpFail);
    statusOne[`DCSM_B_PARITY]  = parErr;
    statusOne[`DCSM_B_PABORT]  = pAbort;
    statusOne[`DCSM_B_LOST]    = lost;
    statusOne[`DCSM_B_SECLEN]  = secLen;
    statusOne[`DCSM_B_EXEC]    = exec;
    statusOne[`DCSM_B_DDENS]   = DOUBLE_DENSITY & ddUnitSel;
    statusOne[`DCSM_B_CMPDONE] = cmpDone;
    statusOne[`DCSM_B_CMPFAIL] = cmpFail;
    statusOne[`DCSM_B_CORR]    = corr;
    statusOne[`DCSM_B_UNCORR]  = uncorr;
  end

  // Word two: checkword serial input, writer data and decode lines
  assign statusTwo = {3'h0, chkSerialIn, 1'b0, writerData, decodes};

  // ****************************************************************
  // Input channel
  // ****************************************************************
  // Output word registered so it is stable for the whole input cycle
  // One cycle of lag is traded for a glitch-free word on the channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inData <= 16'h0000;
    end else begin
      unique case (selCode)
        `DCSM_SEL_STATUS_ONE: inData <= statusOne;
        `DCSM_SEL_REGFILE:    inData <= regFileBus;
        `DCSM_SEL_WORDCNT:    inData <= wordCounter;
        `DCSM_SEL_STATUS_TWO: inData <= statusTwo;
        `DCSM_SEL_DATABUF:    inData <= dataBufOut;
        `DCSM_SEL_CHK_UPPER:  inData <= checkGen[31:16];
        `DCSM_SEL_CHK_LOWER:  inData <= checkGen[15:0];
        `DCSM_SEL_DRIVE:      inData <= driveStable;
        `DCSM_SEL_DIR_OUTER:  inData <= {directorReg[31:24], directorReg[7:0]};
        `DCSM_SEL_BYTECNT:    inData <= byteCounter;
        `DCSM_SEL_POINTERS:   inData <= {2'h0, bitCounter, 3'h0, dirOutPtr, dirInPtr};
        `DCSM_SEL_ADDRESS:    inData <= memAddress;
        `DCSM_SEL_DIR_MIDDLE: inData <= directorReg[23:8];
        default:              inData <= 16'h0000;
      endcase
    end
  end

  // Input answered in the same cycle on channel 04 only
  assign inReply = inStrobe && chanHit(inChannel, `DCSM_IN_CHANNEL);

endmodule
`default_nettype wire

/* File: dcsm_defines.svh */
// Constants of the disk control status multiplexer: channel and select codes, bit positions.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DCSM_DEFINES_SVH
`define DCSM_DEFINES_SVH

// ****************************************************************
// Channel and select codes
// ****************************************************************
`define DCSM_OUT_CHANNEL     8'h09
`define DCSM_IN_CHANNEL      8'h04
`define DCSM_SEL_STATUS_ONE  4'h0
`define DCSM_SEL_REGFILE     4'h1
`define DCSM_SEL_WORDCNT     4'h3
`define DCSM_SEL_STATUS_TWO  4'h4
`define DCSM_SEL_DATABUF     4'h5
`define DCSM_SEL_CHK_UPPER   4'h7
`define DCSM_SEL_CHK_LOWER   4'h8
`define DCSM_SEL_DRIVE       4'h9
`define DCSM_SEL_DIR_OUTER   4'ha
`define DCSM_SEL_BYTECNT     4'hb
`define DCSM_SEL_POINTERS    4'hc
`define DCSM_SEL_ADDRESS     4'hd
`define DCSM_SEL_DIR_MIDDLE  4'hf
// Channel 09 counts bits from the top, so its clear bit 08 is the value 0080
`define DCSM_CLEAR_STATUS_BIT 7
`define DCSM_SEL_RESET       4'h0

// ****************************************************************
// Status word one bit positions
// ****************************************************************
`define DCSM_B_READ    0
`define DCSM_B_WRITE   1
`define DCSM_B_CHKERR  2
`define DCSM_B_COMPOS  3
`define DCSM_B_PARITY  4
`define DCSM_B_PABORT  5
`define DCSM_B_LOST    6
`define DCSM_B_SECLEN  7
`define DCSM_B_EXEC    8
`define DCSM_B_DDENS   9
`define DCSM_B_CMPDONE 11
`define DCSM_B_CMPFAIL 12
`define DCSM_B_CORR    13
`define DCSM_B_UNCORR  14

`endif

/* File: dcsm_pkg.sv */
// Types shared by the disk control status multiplexer.
// Assumes dcsm_defines.svh is on the include path.
`default_nettype none
`include "dcsm_defines.svh"
package dcsm_pkg;
  typedef logic [15:0] dcsm_word_t;
  typedef logic [3:0]  dcsm_sel_t;
endpackage
`default_nettype wire

/* File: dcsm_status_mux_chk.sv */
// Port checker for the status multiplexer.
// Assumes one clk domain and status words registered one cycle late.
`default_nettype none
module dcsm_status_mux_chk #(
  parameter bit DOUBLE_DENSITY = 1'b0  // Option fitted
) (
  input wire logic        clk,          // Clock
  input wire logic        resetn,       // Reset, active low
  input wire logic        masterClear,  // Master clear
  input wire logic [7:0]  outChannel,   // Output channel
  input wire logic        outStrobe,    // Output strobe
  input wire logic [15:0] outData,      // Output word
  input wire logic [7:0]  inChannel,    // Input channel
  input wire logic        inStrobe,     // Input request
  input wire logic [15:0] inData,       // Status word
  input wire logic        inReply,      // Input answered
  input wire logic        parityErr,    // Parity event
  input wire logic [9:0]  decodes,      // Decode levels
  input wire logic        writerData,   // Writer data
  input wire logic        chkSerialIn,  // Generator input
  input wire logic [31:0] checkGen,     // Generator
  input wire logic [31:0] directorReg,  // Director register
  input wire logic [3:0]  dirInPtr,     // Input pointer
  input wire logic [3:0]  dirOutPtr,    // Output pointer
  input wire logic [2:0]  bitCounter,   // Bit counter
  input wire logic        directorHalt  // Halt level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Selection mirror
  // ********************
  logic [3:0] selQ;
  wire        selWr = outStrobe && outChannel == 8'h09;
  // Held selection; the word on inData lags it by one edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) selQ <= 4'h0;
    else if (masterClear) selQ <= 4'h0;
    else if (selWr) selQ <= outData[15:12];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  in_reply_a: assert property (inReply == (inStrobe && inChannel == 8'h04))
    else $error("input reply wrong");
  word_two_a: assert property ($past(selQ) == 4'h4 |->
    inData == {3'h0, $past(chkSerialIn), 1'b0, $past(writerData), $past(decodes)})
    else $error("status two wrong");
  unused_code_a: assert property ($past(selQ) inside {4'h2, 4'h6, 4'he} |-> inData == 16'h0)
    else $error("unused code not zero");
  ptr_pack_a: assert property ($past(selQ) == 4'hc |->
    inData == {2'h0, $past(bitCounter), 3'h0, $past(dirOutPtr), $past(dirInPtr)})
    else $error("pointer word wrong");
  dir_outer_a: assert property ($past(selQ) == 4'ha |->
    inData == {$past(directorReg[31:24]), $past(directorReg[7:0])})
    else $error("director outer wrong");
  chk_upper_a: assert property ($past(selQ) == 4'h7 |-> inData == $past(checkGen[31:16]))
    else $error("checkword half wrong");
  one_unused_a: assert property ($past(selQ) == 4'h0 |->
    !inData[10] && !inData[15] && (DOUBLE_DENSITY || !inData[9]))
    else $error("unused status bit set");
  composite_a: assert property ($past(selQ) == 4'h0 |->
    inData[3] == (|inData[7:4] || inData[2] || (inData[11] && inData[12])))
    else $error("composite bit wrong");
  halt_rise_a: assert property ($rose(directorHalt) |-> $past(parityErr))
    else $error("halt without parity");
  // Main scenarios reached
  cover property (selWr && outData[15:12] == 4'hc);
  cover property ($rose(directorHalt));
  cover property ($past(selQ) == 4'h0 && inData[12]);
endmodule
bind dcsm_status_mux dcsm_status_mux_chk #(.DOUBLE_DENSITY(DOUBLE_DENSITY)) i_chk (
  .clk, .resetn, .masterClear, .outChannel, .outStrobe, .outData, .inChannel,
  .inStrobe, .inData, .inReply, .parityErr, .decodes, .writerData, .chkSerialIn,
  .checkGen, .directorReg, .dirInPtr, .dirOutPtr, .bitCounter, .directorHalt);
`default_nettype wire

/* File: dcsm_proc_model.sv */
// Subsystem processor model on the normal channels.
// Assumes the bench calls its tasks; lines change on falling edges.
`default_nettype none
module dcsm_proc_model (
  input  wire logic        clk,         // Clock
  output logic [7:0]       outChannel,  // Output channel
  output logic             outStrobe,   // Output strobe
  output logic [15:0]      outData,     // Output word
  output logic [7:0]       inChannel,   // Input channel
  output logic             inStrobe,    // Input request
  input  wire logic [15:0] inData,      // Status word
  input  wire logic        inReply      // Input answered
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle lines carry inverted values so stale data never looks valid
  initial begin
    outChannel = 8'hf6;
    outStrobe = 1'b0;
    outData = 16'hffff;
    inChannel = 8'hfb;
    inStrobe = 1'b0;
  end
  // One word on channel 09, strobed for a single cycle
  task automatic writeOut(input logic [15:0] w);
    @(negedge clk);
    outChannel = 8'h09;
    outData = w;
    outStrobe = 1'b1;
    @(negedge clk);
    outStrobe = 1'b0;
    outChannel = 8'hf6;
    outData = ~w;
  endtask
  // Input from channel 04; data taken at the edge that sees the reply
  task automatic readIn(output logic [15:0] w, output bit ok);
    int n;
    ok = 1'b0;
    w = 16'h0;
    @(negedge clk);
    inChannel = 8'h04;
    inStrobe = 1'b1;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      ok = (inReply === 1'b1);
      w = inData;
    end
    @(negedge clk);
    inStrobe = 1'b0;
    inChannel = 8'hfb;
  endtask
endmodule
`default_nettype wire

/* File: tb_dcsm_status_mux.sv */
// Self-checking bench for the status multiplexer.
// Assumes the processor model and the checker are compiled before it.
`default_nettype none
module tb_dcsm_status_mux;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [20:0] ev = '0;
  logic        ddUnitSel, writerData, chkSerialIn, outStrobe, inStrobe, inReply, directorHalt;
  logic [9:0]  decodes;
  logic [15:0] regFileBus, wordCounter, dataBufOut, driveStatusPins, byteCounter, memAddress;
  logic [15:0] outData, inData, got;
  logic [31:0] checkGen, directorReg;
  logic [7:0]  outChannel, inChannel;
  logic [3:0]  dirInPtr, dirOutPtr;
  logic [2:0]  bitCounter;
  int          error_cnt = 0;
  int          compares = 0;
  int          seed = 32'h3a0c;
  int          i, c;
  bit          ok;
  // Event index in the top byte, expected status word one below it
  localparam logic [23:0] SEQ [35] = '{24'h120000, 24'h000001, 24'h01000c, 24'h110000,
    24'h000001, 24'h130000, 24'h020002, 24'h030000, 24'h020002, 24'h080088, 24'h110000,
    24'h090100, 24'h000101, 24'h070048, 24'h110000, 24'h090100, 24'h060028, 24'h110000,
    24'h0c0000, 24'h0d1808, 24'h0c0000, 24'h140800, 24'h0f2800, 24'h0e0800, 24'h104800,
    24'h110000, 24'h090100, 24'h040018, 24'h110018, 24'h090018, 24'h050000, 24'h090100,
    24'h0a0000, 24'h090100, 24'h0b0000};
  always #2 clk = ~clk;
  dcsm_status_mux #(.DOUBLE_DENSITY(1'b1)) i_dut (.clk(clk), .resetn(resetn),
    .masterClear(ev[18]),
    .outChannel(outChannel), .outStrobe(outStrobe), .outData(outData),
    .inChannel(inChannel), .inStrobe(inStrobe), .inData(inData), .inReply(inReply),
    .patternReadStart(ev[0]), .readCheckDone(ev[1] | ev[19]), .readCheckFail(ev[1]),
    .patternWriteStart(ev[2]), .nonWriteDataDir(ev[3]), .parityErr(ev[4]),
    .clearParity(ev[5]), .patternMiss(ev[6]), .bufferUnderOver(ev[7]),
    .sectorOverrun(ev[8]), .executeFunc(ev[9]), .stopFunc(ev[10]), .terminateDir(ev[11]),
    .compareStart(ev[12]), .compareDecided(ev[13] | ev[20]), .compareFailed(ev[13]),
    .correctStart(ev[14]), .correctableEvt(ev[15]), .uncorrectableEvt(ev[16]),
    .ddUnitSel(ddUnitSel), .decodes(decodes), .writerData(writerData),
    .chkSerialIn(chkSerialIn), .regFileBus(regFileBus), .wordCounter(wordCounter),
    .dataBufOut(dataBufOut), .checkGen(checkGen), .driveStatusPins(driveStatusPins),
    .directorReg(directorReg), .byteCounter(byteCounter), .dirInPtr(dirInPtr),
    .dirOutPtr(dirOutPtr), .bitCounter(bitCounter), .memAddress(memAddress),
    .directorHalt(directorHalt));
  dcsm_proc_model i_proc (.clk(clk), .outChannel(outChannel), .outStrobe(outStrobe),
    .outData(outData), .inChannel(inChannel), .inStrobe(inStrobe), .inData(inData),
    .inReply(inReply));
  // Expected word for a select digit, from the live levels
  function automatic logic [15:0] expWord(input logic [3:0] s);
    case (s)
      4'h0: return {6'h00, ddUnitSel, 9'h000}; // Option fitted, no flags raised yet
      4'h1: return regFileBus;
      4'h3: return wordCounter;
      4'h4: return {3'h0, chkSerialIn, 1'b0, writerData, decodes};
      4'h5: return dataBufOut;
      4'h7: return checkGen[31:16];
      4'h8: return checkGen[15:0];
      4'h9: return driveStatusPins;
      4'ha: return {directorReg[31:24], directorReg[7:0]};
      4'hb: return byteCounter;
      4'hc: return {2'h0, bitCounter, 3'h0, dirOutPtr, dirInPtr};
      4'hd: return memAddress;
      4'hf: return directorReg[23:8];
      default: return 16'h0000;
    endcase
  endfunction
  // New random levels on every status source
  task automatic shake();
    {regFileBus, wordCounter} = $random(seed);
    {dataBufOut, driveStatusPins} = $random(seed);
    {byteCounter, memAddress} = $random(seed);
    checkGen = $random(seed);
    directorReg = $random(seed);
    {ddUnitSel, writerData, chkSerialIn, decodes, dirInPtr, dirOutPtr, bitCounter} = $random(seed);
  endtask
  task automatic check(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, a, e);
    end
  endtask
  // A missing reply is a mismatch and ends the run at once
  task automatic readChk(input logic [15:0] e);
    i_proc.readIn(got, ok);
    if (!ok) begin
      check(~e, e);
      finish_test();
    end else begin
      check(got, e);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Every select code twice, low digits set on the second pass; then the flag table
  initial begin
    shake();
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    for (c = 0; c < 32; c++) begin
      @(negedge clk);
      shake();
      i_proc.writeOut({c[3:0], (c > 15) ? 12'h07f : 12'h000});
      repeat (6) @(negedge clk);
      readChk(expWord(c[3:0]));
      shake();
      repeat (6) @(negedge clk);
      readChk(expWord(c[3:0]));
    end
    ddUnitSel = 1'b0;
    for (i = 0; i < 35; i++) begin
      @(negedge clk);
      if (SEQ[i][23:16] == 8'h11)
        i_proc.writeOut(16'h0080);
      else begin
        ev[SEQ[i][20:16]] = 1'b1;
        @(negedge clk);
        ev = '0;
      end
      readChk(SEQ[i][15:0]);
      check({15'h0, directorHalt}, {15'h0, SEQ[i][4]});
    end
    finish_test();
  end
endmodule
`default_nettype wire
